/* File: pkg/dps_params.svh */
// Constants of the delta panel scan drive
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH
// Gate lines driven by the vertical register
`define DPS_GATE_LINES 225
// Horizontal stages, each feeding three colour electrodes
`define DPS_H_STAGES 267
// Signal electrodes across the panel
`define DPS_ELECTRODES 800
// Width of one colour sample
`define DPS_VIDEO_W 8
// Register offsets
`define DPS_REG_CTRL 4'h0
`define DPS_REG_STAT 4'h4
`define DPS_REG_LINES 4'h8
// Control register gate-on bit and its reset value
`define DPS_CTRL_GATE_ON 0
`define DPS_CTRL_GATE_ON_RST 1'b1
`endif

/* File: pkg/dps_pkg.sv */
// Types of the delta panel scan drive
`default_nettype none
`include "dps_params.svh"
package dps_pkg;
  // Asynchronous control pins from the timing generator
  typedef struct packed
  {
    logic vertical_clock_phase_a;
    logic vertical_clock_phase_b;
    logic start;
    logic enable;
    logic clear;
    logic scan_direction_select;
  } dps_vpins_t;

  // One simultaneous colour sample
  typedef struct packed
  {
    logic [`DPS_VIDEO_W-1:0] red;
    logic [`DPS_VIDEO_W-1:0] green;
    logic [`DPS_VIDEO_W-1:0] blue;
  } dps_video_t;

  // Whole state of the control-clock side
  typedef struct packed
  {
    dps_vpins_t pin_s1;
    dps_vpins_t pin_s2;
    logic vck_prev;
    logic [`DPS_GATE_LINES-1:0] gate_sr;
    logic [`DPS_GATE_LINES-1:0] gate_out;
    logic [8:0] line_cnt;
    logic [8:0] frame_lines;
    logic [9:0] hlines;
    logic [9:0] frame_hlines;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_prev;
    logic gate_on;
    logic [31:0] rdata;
  } dps_vstate_t;

  // Whole state of the link-clock side
  typedef struct packed
  {
    logic ce_s1;
    logic ce_s2;
    logic dir_s1;
    logic dir_s2;
    logic hck_prev;
    logic [`DPS_H_STAGES-1:0] h_sr;
    dps_video_t rgb;
    logic line_tgl;
  } dps_hstate_t;
endpackage
`default_nettype wire

/* File: rtl/dps_scan_drive.sv */
// Scan drive of a delta-pattern colour panel: gate and sampling registers
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "dps_params.svh"
module dps_scan_drive
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire dps_pkg::dps_vpins_t vpins,
  input wire logic link_clk,
  input wire logic horizontal_clock_phase_a,
  input wire logic horizontal_clock_phase_b,
  input wire logic h_start,
  input wire dps_pkg::dps_video_t video,
  output logic [`DPS_GATE_LINES-1:0] gate_out,
  output logic [`DPS_H_STAGES-1:0] h_sel,
  output dps_pkg::dps_video_t hold_rgb
);

  // Control-clock state and its next value
  dps_pkg::dps_vstate_t v_q;
  dps_pkg::dps_vstate_t v_d;
  // Link-clock state and its next value
  dps_pkg::dps_hstate_t h_q;
  dps_pkg::dps_hstate_t h_d;
  // Reset release synchroniser for the link side
  logic [1:0] lrst_q;
  // Gate register steps this cycle
  logic v_adv;
  // A finished line arrived from the link side
  logic h_done;
  // Horizontal register steps this cycle
  logic h_adv;
  // Token leaves the far end of the horizontal register
  logic h_end;

  // Control side: pin sync, gate register, counters, registers
  always_comb
  begin
    v_d = v_q;
    v_adv = 1'b0;
    h_done = 1'b0;
    // Read data stands one cycle only
    v_d.rdata = 32'h00000000;
    if (ce)
    begin
      // Two flops on every asynchronous pin
      v_d.pin_s1 = vpins;
      v_d.pin_s2 = v_q.pin_s1;
      v_d.vck_prev = v_q.pin_s2.vertical_clock_phase_a;
      // Line-done toggle from the link domain
      v_d.tgl_s1 = h_q.line_tgl;
      v_d.tgl_s2 = v_q.tgl_s1;
      v_d.tgl_prev = v_q.tgl_s2;
      h_done = (v_q.tgl_s2 != v_q.tgl_prev);
      // Step only on a transition with phases apart
      v_adv = (v_q.pin_s2.vertical_clock_phase_a != v_q.vck_prev) &&
              (v_q.pin_s2.vertical_clock_phase_a != v_q.pin_s2.vertical_clock_phase_b);
      if (h_done)
      begin
        v_d.hlines = v_q.hlines + 10'h001;
      end
      if (v_adv)
      begin
        // Start token enters at the top row and moves down
        v_d.gate_sr = {v_q.gate_sr[`DPS_GATE_LINES-2:0], v_q.pin_s2.start};
        if (v_q.pin_s2.start)
        begin
          // New frame: keep last frame's totals for software
          v_d.line_cnt = 9'h000;
          v_d.frame_lines = v_q.line_cnt;
          v_d.frame_hlines = v_q.hlines;
          v_d.hlines = {9'h000, h_done};
        end
        else
        begin
          v_d.line_cnt = v_q.line_cnt + 9'h001;
        end
      end
      // Select reaches the panel only while enabled
      if (v_q.pin_s2.enable && v_q.gate_on)
      begin
        v_d.gate_out = v_d.gate_sr;
      end
      else
      begin
        v_d.gate_out = '0;
      end
      // Register writes
      if (reg_wr)
      begin
        if (reg_addr == `DPS_REG_CTRL)
        begin
          v_d.gate_on = reg_wdata[`DPS_CTRL_GATE_ON];
        end
      end
      // Register reads, unmapped offsets answer zero
      if (reg_rd)
      begin
        if (reg_addr == `DPS_REG_CTRL)
        begin
          v_d.rdata = {31'h00000000, v_q.gate_on};
        end
        else if (reg_addr == `DPS_REG_STAT)
        begin
          v_d.rdata = {13'h0000, v_q.pin_s2.scan_direction_select, v_q.pin_s2.enable,
                       v_q.pin_s2.clear, 7'h00, v_q.line_cnt};
        end
        else if (reg_addr == `DPS_REG_LINES)
        begin
          v_d.rdata = {6'h00, v_q.frame_hlines, 7'h00, v_q.frame_lines};
        end
        else
        begin
          v_d.rdata = 32'h00000000;
        end
      end
    end
  end

  // Control side register stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      v_q <= '0;
      v_q.gate_on <= `DPS_CTRL_GATE_ON_RST;
    end
    else
    begin
      v_q <= v_d;
    end
  end

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      lrst_q <= 2'h3;
    end
    else
    begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end

  // Link side: horizontal sampling register
  always_comb
  begin
    h_d = h_q;
    h_adv = 1'b0;
    h_end = 1'b0;
    // Enable and direction are levels from elsewhere, two flops each
    h_d.ce_s1 = ce;
    h_d.ce_s2 = h_q.ce_s1;
    h_d.dir_s1 = vpins.scan_direction_select;
    h_d.dir_s2 = h_q.dir_s1;
    if (h_q.ce_s2)
    begin
      h_d.hck_prev = horizontal_clock_phase_a;
      h_adv = (horizontal_clock_phase_a != h_q.hck_prev) &&
              (horizontal_clock_phase_a != horizontal_clock_phase_b);
      if (h_adv)
      begin
        if (h_q.dir_s2)
        begin
          // Left to right: token walks up the index
          h_d.h_sr = {h_q.h_sr[`DPS_H_STAGES-2:0], h_start};
          h_end = h_q.h_sr[`DPS_H_STAGES-1];
        end
        else
        begin
          // Right to left: token walks down the index
          h_d.h_sr = {h_start, h_q.h_sr[`DPS_H_STAGES-1:1]};
          h_end = h_q.h_sr[0];
        end
        // All three colours caught on the same step
        h_d.rgb = video;
        // Token leaving the last stage closes the line
        if (h_end)
        begin
          h_d.line_tgl = ~h_q.line_tgl;
        end
      end
    end
  end

  // Link side register stage
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      h_q <= '0;
    end
    else if (lrst_q[1])
    begin
      h_q <= '0;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = v_q.rdata;
  assign gate_out = v_q.gate_out;
  assign h_sel = h_q.h_sr;
  assign hold_rgb = h_q.rgb;

  // Gate register keeps at most one token across steps without start
  a_gate_single_line: assert property (@(posedge clk) disable iff (rst)
    (!v_q.pin_s2.start && v_adv && $onehot0(v_q.gate_sr)) |=> $onehot0(v_q.gate_sr))
    else $error("gate register holds more than one token");

  // Line counter moves by exactly one per step without start
  a_line_count_step: assert property (@(posedge clk) disable iff (rst)
    (v_adv && !v_q.pin_s2.start) |=> (v_q.line_cnt == $past(v_q.line_cnt) + 9'h001))
    else $error("line counter did not step by one");

  // Token moves one row downward on a step
  a_gate_top_down: assert property (@(posedge clk) disable iff (rst)
    v_adv |=> (v_q.gate_sr[`DPS_GATE_LINES-1:1] == $past(v_q.gate_sr[`DPS_GATE_LINES-2:0])))
    else $error("gate register did not move downward");

  // Disabled enable blanks the gate outputs
  a_enable_blanks: assert property (@(posedge clk) disable iff (rst)
    (ce && !v_q.pin_s2.enable) |=> (gate_out == '0))
    else $error("gate select passed while enable low");

  // Enabled outputs follow the gate register
  a_enable_passes: assert property (@(posedge clk) disable iff (rst)
    (ce && v_q.pin_s2.enable && v_q.gate_on) |=> (gate_out == v_q.gate_sr))
    else $error("gate select withheld while enabled");

  // Frame line total latched and line counter cleared at the start of a frame
  a_frame_latch: assert property (@(posedge clk) disable iff (rst)
    (v_adv && v_q.pin_s2.start) |=> (v_q.frame_lines == $past(v_q.line_cnt) && v_q.line_cnt == 9'h000))
    else $error("frame line total not latched");

  // No step without a clock-pair transition
  a_gate_holds: assert property (@(posedge clk) disable iff (rst)
    (ce && !v_adv) |=> $stable(v_q.gate_sr))
    else $error("gate register moved without a clock transition");

  // Rightward shift when direction high
  a_h_shift_right: assert property (@(posedge link_clk) disable iff (rst || lrst_q[1])
    (h_adv && h_q.dir_s2) |=> (h_q.h_sr == {$past(h_q.h_sr[`DPS_H_STAGES-2:0]), $past(h_start)}))
    else $error("horizontal register not shifting right");

  // Leftward shift when direction low
  a_h_shift_left: assert property (@(posedge link_clk) disable iff (rst || lrst_q[1])
    (h_adv && !h_q.dir_s2) |=> (h_q.h_sr == {$past(h_start), $past(h_q.h_sr[`DPS_H_STAGES-1:1])}))
    else $error("horizontal register not shifting left");

  // Colours held together from one step
  a_rgb_together: assert property (@(posedge link_clk) disable iff (rst || lrst_q[1])
    h_adv |=> (hold_rgb == $past(video)))
    else $error("colour samples not taken together");

  // Line end toggles the line event
  a_line_end_toggle: assert property (@(posedge link_clk) disable iff (rst || lrst_q[1])
    (h_adv && h_end) |=> (h_q.line_tgl != $past(h_q.line_tgl)))
    else $error("finished line not signalled");

  // Main scenarios
  c_frame_start: cover property (@(posedge clk) disable iff (rst)
    v_adv && v_q.pin_s2.start);
  c_bottom_line: cover property (@(posedge clk) disable iff (rst)
    gate_out[`DPS_GATE_LINES-1]);
  c_line_done: cover property (@(posedge clk) disable iff (rst)
    h_done);
  c_left_scan: cover property (@(posedge link_clk) disable iff (rst || lrst_q[1])
    h_adv && !h_q.dir_s2 && h_end);

endmodule
`default_nettype wire

/* File: tb/dps_timing_gen.sv */
// Timing generator model for the far side of the panel scan drive
`timescale 1ns/100ps
`default_nettype none
module dps_timing_gen
(
  input wire logic clk,
  input wire logic link_clk,
  input wire logic en,
  input wire logic dir,
  input wire logic clr,
  output dps_pkg::dps_vpins_t vpins,
  output logic hck_a,
  output logic hck_b,
  output logic h_start,
  output dps_pkg::dps_video_t video
);
  logic ph_a; // Horizontal phase before the swap
  logic ph_b;
  // Leftward scan swaps phases to keep the image centred
  assign hck_a = dir ? ph_a : ph_b;
  assign hck_b = dir ? ph_b : ph_a;
  // Start complementary, enable high, clear low
  initial
  begin
    vpins = 6'h15;
    ph_a = 1'b0;
    ph_b = 1'b1;
    h_start = 1'b0;
    video = '0;
  end
  // Static levels follow the bench settings
  always @(posedge clk)
  begin
    vpins.enable <= en;
    vpins.clear <= clr;
    vpins.scan_direction_select <= dir;
  end
  // Vertical step; levels held well past the pin synchroniser
  task automatic vstep(input logic st);
    @(posedge clk);
    vpins.start <= st;
    vpins.vertical_clock_phase_a <= ~vpins.vertical_clock_phase_a;
    vpins.vertical_clock_phase_b <= vpins.vertical_clock_phase_a;
    repeat (7) @(posedge clk);
  endtask
  // Horizontal step; a bad one leaves both phases equal
  task automatic hstep(input logic st, input dps_pkg::dps_video_t rgb, input logic bad);
    @(posedge link_clk);
    h_start <= st;
    // Colours arrive already aligned, whichever way the scan runs
    video <= rgb;
    // Toggle the pin the panel watches; the other lags it, or joins it on a bad step
    ph_a <= (dir || bad) ? ~hck_a : hck_a;
    ph_b <= (!dir || bad) ? ~hck_a : hck_a;
    repeat (3) @(posedge link_clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_delta_panel_scan_drive.sv */
// Self-checking bench of the delta panel scan drive
`timescale 1ns/100ps
`default_nettype none
`include "dps_params.svh"
module tb_delta_panel_scan_drive;
  logic clk;
  logic link_clk;
  logic rst;
  logic ce; // Control-side clock enable
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic en; // Pin levels handed to the model
  logic dir;
  logic clr;
  dps_pkg::dps_vpins_t vpins;
  logic hck_a;
  logic hck_b;
  logic h_start;
  dps_pkg::dps_video_t video;
  logic [`DPS_GATE_LINES-1:0] gate_out;
  logic [`DPS_H_STAGES-1:0] h_sel;
  dps_pkg::dps_video_t hold_rgb;
  logic [31:0] seed; // Random state
  logic [31:0] rd; // Last word read
  dps_pkg::dps_video_t rgb;
  int mismatches;
  int checks_done;
  dps_scan_drive dps_scan_drive_inst (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vpins(vpins),
    .link_clk(link_clk), .horizontal_clock_phase_a(hck_a), .horizontal_clock_phase_b(hck_b),
    .h_start(h_start), .video(video), .gate_out(gate_out), .h_sel(h_sel), .hold_rgb(hold_rgb));
  dps_timing_gen dps_timing_gen_inst (.clk(clk), .link_clk(link_clk), .en(en), .dir(dir), .clr(clr),
    .vpins(vpins), .hck_a(hck_a), .hck_b(hck_b), .h_start(h_start), .video(video));
  // Control clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Link clock, offset so its edges never meet clk
  initial
  begin
    link_clk = 1'b0;
    #7.3;
    forever #15 link_clk = ~link_clk;
  end
  // Next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected stage select after step k; step 268 empties it
  function automatic logic [266:0] hexp(input logic d, input int k);
    if (k > `DPS_H_STAGES)
      return '0;
    return d ? (267'h1 << (k - 1)) : (267'h1 << (`DPS_H_STAGES - k));
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [266:0] seen, input logic [266:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One write cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One read cycle; data only valid just after the taking edge
  task automatic rdw(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Full line with random colours and one refused step inside
  task automatic hline(input logic d);
    for (int k = 1; k <= `DPS_H_STAGES + 1; k++)
    begin
      if (k == 100)
      begin
        dps_timing_gen_inst.hstep(1'b0, ~rgb, 1'b1);
        #1;
        check("h_refused", 267'(h_sel), hexp(d, 99));
      end
      seed = lfsr(seed);
      // Second line goes in with the opposite polarity
      rgb = d ? seed[23:0] : ~seed[23:0];
      dps_timing_gen_inst.hstep(k == 1, rgb, 1'b0);
      #1;
      check("h_sel", 267'(h_sel), hexp(d, k));
      check("hold_rgb", 267'(hold_rgb), 267'(rgb));
    end
  endtask
  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    en = 1'b1;
    dir = 1'b1;
    clr = 1'b0;
    rgb = '0;
    mismatches = 0;
    checks_done = 0;
    seed = 32'h4F8E6648;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge link_clk);
    check("gate_rst", 267'(gate_out), '0);
    rdw(`DPS_REG_CTRL);
    check("ctrl_rst", 267'(rd), 267'(`DPS_CTRL_GATE_ON_RST));
    wr(`DPS_REG_STAT, 32'hFFFFFFFF);
    rdw(4'hC);
    check("unmapped", 267'(rd), '0);
    // Enable low: bus requests are not taken
    @(posedge clk);
    ce <= 1'b0;
    wr(`DPS_REG_CTRL, 32'h0);
    rdw(`DPS_REG_CTRL);
    check("ce_read", 267'(rd), '0);
    @(posedge clk);
    ce <= 1'b1;
    rdw(`DPS_REG_CTRL);
    check("ce_write", 267'(rd), 267'h1);
    $display("test registers done");
    dps_timing_gen_inst.vstep(1'b1);
    #1;
    check("gate_first", 267'(gate_out), 267'h1);
    hline(1'b1);
    dir <= 1'b0;
    clr <= 1'b1;
    repeat (20) @(posedge link_clk);
    hline(1'b0);
    $display("test horizontal done");
    for (int k = 1; k < `DPS_GATE_LINES; k++)
    begin
      en <= (k != 50);
      dps_timing_gen_inst.vstep(1'b0);
      #1;
      check("gate_out", 267'(gate_out), (k == 50) ? '0 : (267'h1 << k));
    end
    wr(`DPS_REG_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check("gate_off", 267'(gate_out), '0);
    wr(`DPS_REG_CTRL, 32'h1);
    rdw(`DPS_REG_STAT);
    check("stat", 267'(rd), 267'(32'h00030000 | (`DPS_GATE_LINES - 1)));
    dps_timing_gen_inst.vstep(1'b1);
    rdw(`DPS_REG_LINES);
    // Steps after the start step of the frame: one fewer than the rows
    check("lines", 267'(rd), 267'({6'h0, 10'h2, 7'h0, 9'(`DPS_GATE_LINES - 1)}));
    $display("test vertical done");
    print_verdict();
  end
endmodule
`default_nettype wire
